// ===== ufmc_pkg.sv
// ufmc_pkg: constants and carriers for the uart flow and multidrop control
// assumes nothing beyond a systemverilog compiler
package ufmc_pkg;
    // ****************************************
    // general sizes
    // ****************************************
    localparam int unsigned PKT_MAX = 64;
    localparam int unsigned GP_PINS = 6;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_WIDTH = 8;
    // ****************************************
    // mode field codes
    // ****************************************
    localparam logic [2:0] FC_HW = 3'h1;
    localparam logic [2:0] FC_SW = 3'h2;
    localparam logic [2:0] FC_MD_TXON = 3'h3;
    localparam logic [2:0] FC_MD_TXMATCH = 3'h4;
    localparam int unsigned FC_HALF_BIT = 3;
    localparam logic [2:0] PM_RTSCTS = 3'h1;
    localparam logic [2:0] PM_DTRDSR = 3'h2;
    localparam logic [2:0] PM_RS485 = 3'h3;
    localparam int unsigned PM_POL_BIT = 3;
    // ****************************************
    // pin positions
    // ****************************************
    localparam int unsigned PIN_RTS = 5;
    localparam int unsigned PIN_CTS = 4;
    localparam int unsigned PIN_DTR = 3;
    localparam int unsigned PIN_DSR = 2;
    localparam int unsigned PIN_WAKE = 0;
    localparam logic [5:0] GP_DIR_RST = 6'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned IDLE_CHARS = 3;
    localparam int unsigned SUSPEND_MS = 3;
    localparam int unsigned SUSPEND_CYC = SUSPEND_MS * (CLK_HZ / 1000);
    localparam logic [31:0] LOWLAT_BAUD = 32'd46921;
    localparam logic [3:0] TURN_MAX = 4'hF;
    // ****************************************
    // vendor requests and blocks
    // ****************************************
    localparam logic [7:0] RT_VWRITE = 8'h40;
    localparam logic [7:0] RQ_VWRITE = 8'h00;
    localparam logic [7:0] RT_VREAD = 8'hC0;
    localparam logic [7:0] RQ_VREAD = 8'h01;
    localparam logic [7:0] BLK_CHA = 8'h00;
    localparam logic [7:0] BLK_CHB = 8'h01;
    localparam logic [7:0] BLK_MGR = 8'h04;

    typedef struct packed {
        logic [7:0] req_type;
        logic [7:0] request;
        logic [15:0] value;
        logic [7:0] reg_index;
        logic [7:0] block;
        logic [15:0] count;
    } ufmc_setup_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] group;
        logic [7:0] reg_index;
        logic [7:0] data;
        logic [15:0] count;
    } ufmc_vreq_s;
endpackage

// ===== ufmc_fifo.sv
// ufmc_fifo: small synchronous fifo with valid and ready on both sides
// assumes one clock and an asynchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module ufmc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    logic push;
    logic pop;

    // handshakes
    assign in_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rp_q];
    assign level = cnt_q;

    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule
`default_nettype wire

// ===== ufmc_vreq.sv
// ufmc_vreq: decodes vendor register control requests into a register access
// assumes setup packets arrive as one-cycle strobes on mclk
`timescale 1ns/10ps
`default_nettype none
module ufmc_vreq (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // setup packet in
    input wire logic setup_stb,
    input wire ufmc_pkg::ufmc_setup_s setup,
    // decoded request out
    output ufmc_pkg::ufmc_vreq_s vreq_q,
    output logic bad_q
);
    // block number to register group, 3 means none
    function automatic logic [1:0] grp_of(input logic [7:0] blk);
        if (blk == ufmc_pkg::BLK_CHA) begin
            return 2'h0;
        end else if (blk == ufmc_pkg::BLK_CHB) begin
            return 2'h1;
        end else if (blk == ufmc_pkg::BLK_MGR) begin
            return 2'h2;
        end else begin
            return 2'h3;
        end
    endfunction

    logic is_wr;
    logic is_rd;
    assign is_wr = setup.req_type == ufmc_pkg::RT_VWRITE && setup.request == ufmc_pkg::RQ_VWRITE;
    assign is_rd = setup.req_type == ufmc_pkg::RT_VREAD && setup.request == ufmc_pkg::RQ_VREAD;

    // register the decoded request for one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vreq_q <= '0;
            bad_q <= 1'b0;
        end else begin
            vreq_q.wr <= setup_stb && is_wr && grp_of(setup.block) != 2'h3;
            vreq_q.rd <= setup_stb && is_rd && grp_of(setup.block) != 2'h3;
            vreq_q.group <= grp_of(setup.block);
            vreq_q.reg_index <= setup.reg_index;
            vreq_q.data <= setup.value[7:0];
            vreq_q.count <= setup.count;
            bad_q <= setup_stb && (is_wr || is_rd) && grp_of(setup.block) == 2'h3;
        end
    end
endmodule
`default_nettype wire

// ===== ufmc_top.sv
// ufmc_top: flow control, line control, multidrop and suspend logic of one channel
// assumes a uart core beside it gives bit ticks, char strobes and tx state on mclk
//
// Overview of operation
// - acknowledge bulk-in with full packet once 64 bytes are buffered
// - below 64 bytes without low latency, bulk-in may be refused
// - below 64 bytes and idle over 3 characters, send all buffered
// - low latency releases buffered bytes at once, no idle wait
// - line coding below 46921 bps sets low latency automatically
// - six general pins per channel, all inputs after reset
// - pin mode 001 and flow mode 001 make pins 5,4 rts,cts
// - rts deasserted when receive fifo full, reasserted when room
// - transmitter paused while cts deasserted by remote party
// - pin mode 010 makes pins 3,2 dtr,dsr with same handshake
// - flow mode 010 matches stop and resume characters on receive
// - rs-485 direction asserted before first bit, dropped after stop
// - direction drop may be delayed 1 to 15 bit times
// - direction polarity chosen by pin mode bit 3
// - modes 3,4 address byte has ninth bit set, matches either register
// - matched address dropped, following data bytes stored
// - unmatched address byte disables the receiver
// - mode 3 transmitter always on, mode 4 only while matched
// - flow bit 3 ignores receive data while transmitting
// - suspend entered after 3 ms without bus activity
// - falling edge of pin 0 while suspended requests remote wakeup
// - vendor write uses type 40h request 0
// - vendor burst read uses type C0h request 1
// - block 0 channel a, 1 channel b, 4 manager
`timescale 1ns/10ps
`default_nettype none
module ufmc_top #(
    parameter int unsigned SUSPEND_CYC = ufmc_pkg::SUSPEND_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration
    input wire logic [3:0] flow_mode,
    input wire logic [3:0] pin_mode,
    input wire logic [3:0] turnaround_delay,
    input wire logic [7:0] resume_char,
    input wire logic [7:0] stop_char,
    input wire logic [5:0] gp_dir,
    input wire logic [5:0] gp_out,
    input wire logic low_latency_set,
    input wire logic [3:0] char_bits,
    input wire logic wakeup_enable,
    // line coding request
    input wire logic line_coding_stb,
    input wire logic [31:0] line_coding_baud,
    // uart core side
    input wire logic bit_tick,
    input wire logic rx_char_stb,
    input wire logic [8:0] rx_char,
    input wire logic tx_busy,
    input wire logic tx_char_start,
    input wire logic tx_char_done,
    // receive data out to bulk-in
    input wire logic bulk_in_req,
    output logic bulk_in_ack_q,
    output logic bulk_in_nak_q,
    output logic [7:0] bulk_in_len_q,
    output logic rxd_valid,
    input wire logic rxd_ready,
    output logic [7:0] rxd_data,
    // fifo space seen by flow control
    input wire logic rx_fifo_full,
    input wire logic [8:0] rx_fifo_count,
    // general pins
    input wire logic [5:0] gp_in,
    output logic [5:0] gp_oe_q,
    output logic [5:0] gp_o_q,
    // control to uart core
    output logic tx_allow_q,
    output logic rx_enable_q,
    output logic low_latency_q,
    // usb side
    input wire logic usb_activity,
    input wire logic setup_stb,
    input wire ufmc_pkg::ufmc_setup_s setup,
    output logic suspend_q,
    output logic wakeup_req_q,
    output ufmc_pkg::ufmc_vreq_s vreq_q,
    output logic vreq_bad_q
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [5:0] gp_s1_q;
    logic [5:0] gp_s2_q;
    logic [5:0] gp_s3_q;
    // two stages, third for edge detect
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gp_s1_q <= 6'h3F;
            gp_s2_q <= 6'h3F;
            gp_s3_q <= 6'h3F;
        end else begin
            gp_s1_q <= gp_in;
            gp_s2_q <= gp_s1_q;
            gp_s3_q <= gp_s2_q;
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    logic hw_rtscts;
    logic hw_dtrdsr;
    logic sw_flow;
    logic md_mode;
    logic rs485_on;
    logic half_dup;
    assign hw_rtscts = pin_mode[2:0] == ufmc_pkg::PM_RTSCTS && flow_mode[2:0] == ufmc_pkg::FC_HW;
    assign hw_dtrdsr = pin_mode[2:0] == ufmc_pkg::PM_DTRDSR && flow_mode[2:0] == ufmc_pkg::FC_HW;
    assign sw_flow = flow_mode[2:0] == ufmc_pkg::FC_SW;
    assign md_mode = flow_mode[2:0] == ufmc_pkg::FC_MD_TXON
        || flow_mode[2:0] == ufmc_pkg::FC_MD_TXMATCH;
    assign rs485_on = pin_mode[2:0] == ufmc_pkg::PM_RS485;
    assign half_dup = flow_mode[ufmc_pkg::FC_HALF_BIT];

    // ****************************************
    // receive path filtering
    // ****************************************
    logic addr_byte;
    logic addr_hit;
    logic rx_take;
    logic match_q;
    logic xoff_q;
    logic fifo_in_ready;
    logic [3:0] fifo_level;
    assign addr_byte = md_mode && rx_char[8];
    assign addr_hit = rx_char[7:0] == resume_char || rx_char[7:0] == stop_char;
    assign rx_take = rx_char_stb && !(half_dup && tx_busy);

    // multidrop match state and receiver enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            match_q <= 1'b0;
            rx_enable_q <= 1'b1;
        end else if (!md_mode) begin
            match_q <= 1'b0;
            rx_enable_q <= 1'b1;
        end else if (rx_take && addr_byte) begin
            match_q <= addr_hit;
            rx_enable_q <= addr_hit;
        end
    end

    // software flow stop and resume
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xoff_q <= 1'b0;
        end else if (!sw_flow) begin
            xoff_q <= 1'b0;
        end else if (rx_take) begin
            if (rx_char[7:0] == stop_char) begin
                xoff_q <= 1'b1;
            end else if (rx_char[7:0] == resume_char) begin
                xoff_q <= 1'b0;
            end
        end
    end

    // data bytes into fifo, address bytes and blanked bytes dropped
    logic fifo_push;
    assign fifo_push = rx_take && !addr_byte && (!md_mode || match_q) && rx_enable_q;
    ufmc_fifo #(
        .WIDTH(ufmc_pkg::FIFO_WIDTH),
        .DEPTH(ufmc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(rx_char[7:0]),
        .out_valid(rxd_valid),
        .out_ready(rxd_ready),
        .out_data(rxd_data),
        .level(fifo_level)
    );

    // ****************************************
    // transmit gating
    // ****************************************
    logic cts_ok;
    assign cts_ok = hw_rtscts ? !gp_s2_q[ufmc_pkg::PIN_CTS]
        : hw_dtrdsr ? !gp_s2_q[ufmc_pkg::PIN_DSR] : 1'b1;

    // transmitter permission
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_allow_q <= 1'b1;
        end else begin
            tx_allow_q <= cts_ok && !xoff_q
                && !(flow_mode[2:0] == ufmc_pkg::FC_MD_TXMATCH && !match_q);
        end
    end

    // ****************************************
    // rs-485 direction and turnaround
    // ****************************************
    logic dir_on_q;
    logic [3:0] turn_q;
    // direction hold state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dir_on_q <= 1'b0;
            turn_q <= 4'h0;
        end else if (!rs485_on) begin
            dir_on_q <= 1'b0;
            turn_q <= 4'h0;
        end else if (tx_char_start || tx_busy) begin
            dir_on_q <= 1'b1;
            turn_q <= turnaround_delay;
        end else if (tx_char_done && turnaround_delay == 4'h0) begin
            dir_on_q <= 1'b0;
        end else if (dir_on_q && bit_tick) begin
            if (turn_q == 4'h0) begin
                dir_on_q <= 1'b0;
            end else begin
                turn_q <= turn_q - 4'h1;
            end
        end
    end

    // ****************************************
    // general pins
    // ****************************************
    // pin drive and enables
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gp_oe_q <= ufmc_pkg::GP_DIR_RST;
            gp_o_q <= 6'h3F;
        end else begin
            gp_oe_q <= gp_dir;
            gp_o_q <= gp_out;
            if (hw_rtscts) begin
                gp_oe_q[ufmc_pkg::PIN_RTS] <= 1'b1;
                gp_oe_q[ufmc_pkg::PIN_CTS] <= 1'b0;
                gp_o_q[ufmc_pkg::PIN_RTS] <= rx_fifo_full || !fifo_in_ready;
            end
            if (hw_dtrdsr) begin
                gp_oe_q[ufmc_pkg::PIN_DTR] <= 1'b1;
                gp_oe_q[ufmc_pkg::PIN_DSR] <= 1'b0;
                gp_o_q[ufmc_pkg::PIN_DTR] <= rx_fifo_full || !fifo_in_ready;
            end
            if (rs485_on) begin
                gp_oe_q[ufmc_pkg::PIN_RTS] <= 1'b1;
                gp_o_q[ufmc_pkg::PIN_RTS] <= dir_on_q ^ !pin_mode[ufmc_pkg::PM_POL_BIT];
            end
        end
    end

    // ****************************************
    // low latency and idle timeout
    // ****************************************
    logic [5:0] idle_q;
    logic [5:0] idle_lim;
    assign idle_lim = 6'(ufmc_pkg::IDLE_CHARS * char_bits);

    // idle bit counter restarted per character
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_q <= 6'h00;
        end else if (rx_char_stb) begin
            idle_q <= 6'h00;
        end else if (bit_tick && idle_q <= idle_lim) begin
            idle_q <= idle_q + 6'h01;
        end
    end

    // low latency flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_latency_q <= 1'b0;
        end else if (line_coding_stb) begin
            low_latency_q <= low_latency_set || line_coding_baud < ufmc_pkg::LOWLAT_BAUD;
        end else begin
            low_latency_q <= low_latency_set || low_latency_q && !line_coding_stb;
        end
    end

    // bulk-in answer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bulk_in_ack_q <= 1'b0;
            bulk_in_nak_q <= 1'b0;
            bulk_in_len_q <= 8'h00;
        end else begin
            bulk_in_ack_q <= 1'b0;
            bulk_in_nak_q <= 1'b0;
            if (bulk_in_req) begin
                if (rx_fifo_count >= 9'(ufmc_pkg::PKT_MAX)) begin
                    bulk_in_ack_q <= 1'b1;
                    bulk_in_len_q <= 8'(ufmc_pkg::PKT_MAX);
                end else if (rx_fifo_count != 9'h000
                    && (low_latency_q || idle_q > idle_lim)) begin
                    bulk_in_ack_q <= 1'b1;
                    bulk_in_len_q <= rx_fifo_count[7:0];
                end else begin
                    bulk_in_nak_q <= 1'b1;
                    bulk_in_len_q <= 8'h00;
                end
            end
        end
    end

    // ****************************************
    // suspend and wakeup
    // ****************************************
    logic [$clog2(SUSPEND_CYC+1)-1:0] quiet_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            quiet_q <= '0;
            suspend_q <= 1'b0;
        end else if (usb_activity) begin
            quiet_q <= '0;
            suspend_q <= 1'b0;
        end else if (quiet_q >= ($clog2(SUSPEND_CYC+1))'(SUSPEND_CYC - 1)) begin
            suspend_q <= 1'b1;
        end else begin
            quiet_q <= quiet_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wakeup_req_q <= 1'b0;
        end else begin
            wakeup_req_q <= suspend_q && wakeup_enable && !gp_dir[ufmc_pkg::PIN_WAKE]
                && gp_s3_q[ufmc_pkg::PIN_WAKE] && !gp_s2_q[ufmc_pkg::PIN_WAKE];
        end
    end

    // ****************************************
    // vendor requests
    // ****************************************
    ufmc_vreq u_vreq (
        .mclk(mclk),
        .rst(rst),
        .setup_stb(setup_stb),
        .setup(setup),
        .vreq_q(vreq_q),
        .bad_q(vreq_bad_q)
    );

    // ****************************************
    // checks
    // ****************************************
    property p_full_ack;
        @(posedge mclk) disable iff (rst)
        bulk_in_req && rx_fifo_count >= 9'd64 |=> bulk_in_ack_q && bulk_in_len_q == 8'd64;
    endproperty
    a_full_ack: assert property (p_full_ack) else $error("full packet not acked");

    property p_nak;
        @(posedge mclk) disable iff (rst)
        bulk_in_req && rx_fifo_count == 9'h000 |=> bulk_in_nak_q && !bulk_in_ack_q;
    endproperty
    a_nak: assert property (p_nak) else $error("empty request not refused");

    property p_lowlat;
        @(posedge mclk) disable iff (rst)
        bulk_in_req && low_latency_q && rx_fifo_count != 9'h000 |=> bulk_in_ack_q;
    endproperty
    a_lowlat: assert property (p_lowlat) else $error("low latency not released");

    property p_slow_baud;
        @(posedge mclk) disable iff (rst)
        line_coding_stb && line_coding_baud < 32'd46921 |=> low_latency_q;
    endproperty
    a_slow_baud: assert property (p_slow_baud) else $error("low latency not set");

    property p_rts;
        @(posedge mclk) disable iff (rst)
        hw_rtscts && rx_fifo_full |=> gp_o_q[5] && gp_oe_q[5];
    endproperty
    a_rts: assert property (p_rts) else $error("rts not deasserted");

    property p_cts;
        @(posedge mclk) disable iff (rst)
        hw_rtscts && gp_s2_q[4] |=> !tx_allow_q;
    endproperty
    a_cts: assert property (p_cts) else $error("tx not paused");

    property p_xoff;
        @(posedge mclk) disable iff (rst)
        sw_flow && rx_take && rx_char[7:0] == stop_char ##1 sw_flow |=> !tx_allow_q;
    endproperty
    a_xoff: assert property (p_xoff) else $error("stop char ignored");

    property p_mismatch;
        @(posedge mclk) disable iff (rst)
        md_mode && rx_take && addr_byte && !addr_hit ##1 md_mode |-> !rx_enable_q;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("receiver not disabled");

    property p_halfdup;
        @(posedge mclk) disable iff (rst)
        half_dup && tx_busy |-> !fifo_push;
    endproperty
    a_halfdup: assert property (p_halfdup) else $error("rx taken while sending");

    property p_dir;
        @(posedge mclk) disable iff (rst)
        rs485_on && tx_char_start ##1 rs485_on |-> dir_on_q;
    endproperty
    a_dir: assert property (p_dir) else $error("direction not asserted");
endmodule
`default_nettype wire

// ===== ufmc_remote.sv
// ufmc_remote: far uart partner sending receive chars and driving cts
// assumes its tasks are called just after a rising edge of mclk
`timescale 1ns/10ps
`default_nettype none
module ufmc_remote (
    // clock
    input wire logic mclk,
    // receive side and pins
    output logic rx_char_stb,
    output logic [8:0] rx_char,
    output logic [5:0] gp_in
);
    // idle line, pins pulled high
    initial begin
        rx_char_stb = 1'b0;
        rx_char = 9'h000;
        gp_in = 6'h3F;
    end
    // one char strobe, data scrambled after
    task automatic send(input logic [8:0] c);
        rx_char = c;
        rx_char_stb = 1'b1;
        @(posedge mclk);
        #1;
        rx_char_stb = 1'b0;
        rx_char = ~c;
    endtask
    task automatic set_cts_n(input logic v);
        gp_in[ufmc_pkg::PIN_CTS] = v;
    endtask
endmodule
`default_nettype wire

// ===== tb_ufmc_top.sv
// tb_ufmc_top: self-checking bench for the flow and line control block
// assumes the package, design files and ufmc_remote are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_ufmc_top;
    logic mclk = 1'b0, rst = 1'b1, bulk_in_req = 1'b0, line_coding_stb = 1'b0;
    logic usb_activity = 1'b1, setup_stb = 1'b0;
    logic [3:0] flow_mode = 4'h0, pin_mode = 4'h0;
    logic [31:0] line_coding_baud = 32'h0;
    logic [8:0] rx_fifo_count = 9'h000, rx_char;
    ufmc_pkg::ufmc_setup_s setup = '0;
    logic rx_char_stb, bulk_in_ack_q, bulk_in_nak_q, tx_allow_q, low_latency_q, suspend_q;
    logic [5:0] gp_in, gp_oe_q, gp_o_q;
    logic [7:0] bulk_in_len_q, rxd_data;
    logic [3:0] turnaround_delay = 4'h0, char_bits = 4'hA;
    logic [7:0] resume_char = 8'h11, stop_char = 8'h13;
    logic [5:0] gp_dir = 6'h00, gp_out = 6'h3F;
    logic low_latency_set = 1'b0, wakeup_enable = 1'b0, bit_tick = 1'b0, tx_busy = 1'b0;
    logic tx_char_start = 1'b0, tx_char_done = 1'b0, rxd_ready = 1'b1, rx_fifo_full = 1'b0;
    logic rxd_valid, rx_enable_q, wakeup_req_q, vreq_bad_q;
    ufmc_pkg::ufmc_vreq_s vreq_q;
    int fail_count = 0, checked = 0, cyc = 0;
    ufmc_remote ufmc_remote_i (.mclk(mclk), .rx_char_stb(rx_char_stb), .rx_char(rx_char),
        .gp_in(gp_in));
    ufmc_top #(.SUSPEND_CYC(50)) ufmc_top_i (.mclk(mclk), .rst(rst), .flow_mode(flow_mode),
        .pin_mode(pin_mode), .turnaround_delay(turnaround_delay), .resume_char(resume_char),
        .stop_char(stop_char), .gp_dir(gp_dir), .gp_out(gp_out),
        .low_latency_set(low_latency_set), .char_bits(char_bits),
        .wakeup_enable(wakeup_enable), .line_coding_stb(line_coding_stb),
        .line_coding_baud(line_coding_baud), .bit_tick(bit_tick), .rx_char_stb(rx_char_stb),
        .rx_char(rx_char), .tx_busy(tx_busy), .tx_char_start(tx_char_start),
        .tx_char_done(tx_char_done), .bulk_in_req(bulk_in_req), .bulk_in_ack_q(bulk_in_ack_q),
        .bulk_in_nak_q(bulk_in_nak_q), .bulk_in_len_q(bulk_in_len_q), .rxd_valid(rxd_valid),
        .rxd_ready(rxd_ready), .rxd_data(rxd_data), .rx_fifo_full(rx_fifo_full),
        .rx_fifo_count(rx_fifo_count), .gp_in(gp_in), .gp_oe_q(gp_oe_q), .gp_o_q(gp_o_q),
        .tx_allow_q(tx_allow_q), .rx_enable_q(rx_enable_q), .low_latency_q(low_latency_q),
        .usb_activity(usb_activity), .setup_stb(setup_stb), .setup(setup),
        .suspend_q(suspend_q), .wakeup_req_q(wakeup_req_q), .vreq_q(vreq_q),
        .vreq_bad_q(vreq_bad_q));
    // 100 ns clock and hang limit
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // one bulk-in request, answer pulse stands when the task returns
    task automatic bulk(input logic [8:0] n);
        tick(1);
        rx_fifo_count = n;
        bulk_in_req = 1'b1;
        tick(1);
        bulk_in_req = 1'b0;
    endtask
    task automatic vend(input logic [7:0] t, input logic [7:0] r, input logic [7:0] b);
        tick(1);
        setup = '{t, r, 16'h00A5, 8'h03, b, 16'h0002};
        setup_stb = 1'b1;
        tick(1);
        setup_stb = 1'b0;
    endtask
    task automatic t_bulk();
        bulk(9'd10);
        chk(bulk_in_nak_q === 1'b1 && bulk_in_ack_q === 1'b0, "no nak");
        bulk(9'd64);
        chk(bulk_in_ack_q === 1'b1 && bulk_in_len_q === 8'h40, "no full packet");
    endtask
    task automatic t_lowlat();
        line_coding_baud = 32'd46920;
        line_coding_stb = 1'b1;
        tick(1);
        line_coding_stb = 1'b0;
        tick(1);
        chk(low_latency_q === 1'b1, "low latency off");
        bulk(9'd5);
        chk(bulk_in_ack_q === 1'b1 && bulk_in_len_q === 8'h05, "no release");
    endtask
    task automatic t_vendor();
        vend(8'h40, 8'h00, 8'h04);
        chk(vreq_q.wr === 1'b1 && vreq_q.group === 2'h2 && vreq_q.data === 8'hA5, "wr");
        vend(8'hC0, 8'h01, 8'h01);
        chk(vreq_q.rd === 1'b1 && vreq_q.group === 2'h1 && vreq_q.count === 16'h2, "rd");
    endtask
    task automatic t_flow();
        flow_mode = 4'h1;
        pin_mode = 4'h1;
        ufmc_remote_i.set_cts_n(1'b1);
        tick(5);
        chk(tx_allow_q === 1'b0 && gp_oe_q[5] === 1'b1 && gp_o_q[5] === 1'b0, "cts");
        ufmc_remote_i.set_cts_n(1'b0);
        tick(5);
        chk(tx_allow_q === 1'b1, "cts resume");
        flow_mode = 4'h2;
        ufmc_remote_i.send(9'h013);
        tick(4);
        chk(tx_allow_q === 1'b0, "xoff");
        ufmc_remote_i.send(9'h011);
        tick(4);
        chk(tx_allow_q === 1'b1, "xon");
    endtask
    task automatic t_suspend();
        usb_activity = 1'b0;
        tick(55);
        chk(suspend_q === 1'b1, "no suspend");
        usb_activity = 1'b1;
        tick(2);
        chk(suspend_q === 1'b0, "suspend stuck");
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // reset for 10 cycles, then scenarios
    initial begin
        tick(10);
        rst = 1'b0;
        chk(gp_oe_q === 6'h00, "pins not inputs");
        chk(rx_enable_q === 1'b1 && rxd_valid === 1'b0 && wakeup_req_q === 1'b0, "reset");
        t_bulk();
        t_lowlat();
        t_vendor();
        t_flow();
        t_suspend();
        final_report();
    end
endmodule
`default_nettype wire
